/* design/ihc_defs.svh */
// Purpose: Constants of the internal frame header codec
// Assumes: Included by package and top; bit ranges other than IHC_CTRL_PFX are header bit numbers
// Notes:   Ranges are written hi:lo and used as part-selects
`ifndef IHC_DEFS_SVH
`define IHC_DEFS_SVH
// ----------------------------------------
// Header geometry
// ----------------------------------------
`define IHC_HDR_BYTES   28
`define IHC_HDR_W       224
`define IHC_TS          223:192
`define IHC_DST         191:128
`define IHC_STK         127:48
`define IHC_LOW         47:0
`define IHC_MODE        40:38
// ----------------------------------------
// Destination layouts
// ----------------------------------------
`define IHC_INJ_RSV     191:181
`define IHC_INJ_MASK    180:128
`define IHC_EN_RSVA     191:190
`define IHC_EN_HOP      189
`define IHC_EN_SWAP     188
`define IHC_EN_TAG      187:186
`define IHC_EN_RSVB     185:184
`define IHC_EN_GIDX     183:174
`define IHC_EN_GKIND    173
`define IHC_EN_PROT     172
`define IHC_EN_PUOFF    171:166
`define IHC_EN_PUKIND   165:163
`define IHC_EN_CLASS    162:147
`define IHC_EN_TTL      146:139
`define IHC_EN_SBIT     138
`define IHC_EN_NEXT     134:133
`define IHC_EN_STRIP    132:128
`define IHC_UC_RSV      191:183
`define IHC_UC_LEG      182:176
`define IHC_UC_MAC      175:128
`define IHC_MC_RSV      191:152
`define IHC_MC_GRP      151:142
`define IHC_MC_LEG      141:135
`define IHC_MC_COPY     134:128
// ----------------------------------------
// Registers, fields, timing
// ----------------------------------------
`define IHC_REG_CTRL    8'h00
`define IHC_REG_TIME    8'h04
`define IHC_REG_BCNT    8'h08
`define IHC_REG_PCNT    8'h0C
`define IHC_REG_ECNT    8'h10
`define IHC_REG_CAUSE   8'h14
`define IHC_CTRL_BLD    0
`define IHC_CTRL_PRS    1
`define IHC_CTRL_DROP   2
`define IHC_CTRL_PFX    15:8
`define IHC_CTRL_RST    32'h0000_0003
`define IHC_CNT_RST     32'h0000_0000
`define IHC_CLK_MHZ     50
`define IHC_NS_PER_CYC  (1000 / `IHC_CLK_MHZ)
`define IHC_ERR_W       4
`define IHC_ERR_MODE    0
`define IHC_ERR_RSV     1
`define IHC_ERR_GKIND   2
`define IHC_ERR_CODE    3
`endif

/* design/ihc_pkg.sv */
// Purpose: Types of the internal frame header codec
// Assumes: ihc_defs.svh on the include path
// Notes:   Field struct is shared by builder, parser and top
`default_nettype none
package ihc_pkg;
`include "ihc_defs.svh"
	typedef logic [`IHC_HDR_W-1:0] ihc_hdr_t;
	typedef logic [31:0]           ihc_ts_t;
	typedef logic [`IHC_ERR_W-1:0] ihc_err_t;
	typedef enum logic [2:0] {
		IHC_LAYOUT_ENCAPSULATION_LAYOUT  = 3'b000,
		IHC_LAYOUT_UCAST  = 3'b001,
		IHC_LAYOUT_MCAST  = 3'b010,
		IHC_LAYOUT_INJECT = 3'b011
	} ihc_layout_e;
	typedef enum logic [2:0] {
		IHC_PU_NONE = 3'b000, IHC_PU_Y1731 = 3'b001, IHC_PU_MPLSTP = 3'b010,
		IHC_PU_PTP = 3'b011, IHC_PU_PTP_IP4 = 3'b100, IHC_PU_PTP_IP6 = 3'b101,
		IHC_PU_RSV = 3'b110, IHC_PU_SAM = 3'b111
	} ihc_pu_kind_e;
	typedef enum logic [1:0] {
		IHC_NEXT_ETH = 2'b00, IHC_NEXT_CW = 2'b01,
		IHC_NEXT_MPLS = 2'b10, IHC_NEXT_RSV = 2'b11
	} ihc_next_e;
	typedef struct packed {
		logic [31:0] arrival_time_ns;
		logic [2:0]  destination_layout_select;
		logic [52:0] port_mask;
		logic        routed_hop_update;
		logic        mac_exchange;
		logic [1:0]  tag_protocol_select;
		logic [9:0]  generic_index;
		logic        generic_index_kind;
		logic        protection_active;
		logic [5:0]  payload_unit_offset;
		logic [2:0]  payload_unit_kind;
		logic [15:0] classification_match;
		logic [7:0]  label_hop_limit;
		logic        label_bottom_flag;
		logic [1:0]  next_header_kind;
		logic [4:0]  halfword_strip_count;
		logic [6:0]  egress_router_leg;
		logic [47:0] next_hop_mac;
		logic [9:0]  multicast_group_index;
		logic [6:0]  routed_copy_count;
		logic [79:0] stack_section;
		logic [47:0] low_fields;
	} ihc_fields_s;
endpackage : ihc_pkg
`default_nettype wire

/* design/ihc_stage_if.sv */
// Purpose: Carrier between top and one codec stage
// Assumes: ihc_pkg compiled first
// Notes:   Each stage uses only part of the signals
`timescale 1ns/10ps
`default_nettype none
interface ihc_stage_if;
	import ihc_pkg::*;
	logic        in_valid;
	ihc_fields_s in_fields;
	ihc_hdr_t    in_hdr;
	logic        out_valid;
	ihc_hdr_t    out_hdr;
	ihc_fields_s out_fields;
	ihc_err_t    out_err;
	modport stage (input in_valid, in_fields, in_hdr,
		output out_valid, out_hdr, out_fields, out_err);
	modport core (output in_valid, in_fields, in_hdr,
		input out_valid, out_hdr, out_fields, out_err);
endinterface : ihc_stage_if
`default_nettype wire

/* design/ihc_build.sv */
// Purpose: Packs extraction fields into the 224-bit header
// Assumes: Fields arrive one cycle with in_valid
// Notes:   Reserved bits of every layout come out zero
`timescale 1ns/10ps
`default_nettype none
module ihc_build (
	input wire logic       core_clk,
	input wire logic       arst_n,
	input wire ihc_pkg::ihc_ts_t time_ns,
	ihc_stage_if.stage     st
);
	import ihc_pkg::*;

	// Field packing by destination layout
	function automatic ihc_hdr_t ihc_pack(input ihc_fields_s f, input ihc_ts_t ts);
		ihc_hdr_t h;
		h = '0;
		h[`IHC_TS]   = ts;
		h[`IHC_STK]  = f.stack_section;
		h[`IHC_LOW]  = f.low_fields;
		h[`IHC_MODE] = f.destination_layout_select;
		case (f.destination_layout_select)
			IHC_LAYOUT_ENCAPSULATION_LAYOUT: begin
				h[`IHC_EN_HOP]    = f.routed_hop_update;
				h[`IHC_EN_SWAP]   = f.mac_exchange;
				h[`IHC_EN_TAG]    = f.tag_protocol_select;
				h[`IHC_EN_GIDX]   = f.generic_index;
				h[`IHC_EN_GKIND]  = f.generic_index_kind;
				h[`IHC_EN_PROT]   = f.protection_active;
				h[`IHC_EN_PUOFF]  = f.payload_unit_offset;
				h[`IHC_EN_PUKIND] = f.payload_unit_kind;
				h[`IHC_EN_CLASS]  = f.classification_match;
				h[`IHC_EN_TTL]    = f.label_hop_limit;
				h[`IHC_EN_SBIT]   = f.label_bottom_flag;
				h[`IHC_EN_NEXT]   = f.next_header_kind;
				h[`IHC_EN_STRIP]  = f.halfword_strip_count;
			end
			IHC_LAYOUT_UCAST: begin
				h[`IHC_UC_LEG] = f.egress_router_leg;
				h[`IHC_UC_MAC] = f.next_hop_mac;
			end
			IHC_LAYOUT_MCAST: begin
				h[`IHC_MC_GRP]  = f.multicast_group_index;
				h[`IHC_MC_LEG]  = f.egress_router_leg;
				h[`IHC_MC_COPY] = f.routed_copy_count;
			end
			IHC_LAYOUT_INJECT: h[`IHC_INJ_MASK] = f.port_mask;
			default: h[`IHC_DST] = '0; // Reserved modes carry no destination
		endcase
		return h;
	endfunction : ihc_pack

	// Registered header, one cycle after the request
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			st.out_valid <= 1'b0;
			st.out_hdr   <= '0;
		end else begin
			st.out_valid <= st.in_valid;
			if (st.in_valid) begin
				st.out_hdr <= ihc_pack(st.in_fields, time_ns);
			end
		end
	end

	// Unused stage outputs
	assign st.out_fields = '0;
	assign st.out_err    = '0;
endmodule : ihc_build
`default_nettype wire

/* design/ihc_parse.sv */
// Purpose: Splits an injected header into fields and checks it
// Assumes: Header arrives one cycle with in_valid
// Notes:   Undefined encapsulation bits 137:135 are ignored
`timescale 1ns/10ps
`default_nettype none
module ihc_parse (
	input wire logic   core_clk,
	input wire logic   arst_n,
	ihc_stage_if.stage st
);
	import ihc_pkg::*;

	ihc_fields_s f_d;
	ihc_err_t    e_d;

	// Field extraction and reserved checks
	always_comb begin
		f_d = '0;
		e_d = '0;
		f_d.arrival_time_ns           = st.in_hdr[`IHC_TS];
		f_d.stack_section             = st.in_hdr[`IHC_STK];
		f_d.low_fields                = st.in_hdr[`IHC_LOW];
		f_d.destination_layout_select = st.in_hdr[`IHC_MODE];
		case (st.in_hdr[`IHC_MODE])
			IHC_LAYOUT_ENCAPSULATION_LAYOUT: begin
				f_d.routed_hop_update    = st.in_hdr[`IHC_EN_HOP];
				f_d.mac_exchange         = st.in_hdr[`IHC_EN_SWAP];
				f_d.tag_protocol_select  = st.in_hdr[`IHC_EN_TAG];
				f_d.generic_index        = st.in_hdr[`IHC_EN_GIDX];
				f_d.generic_index_kind   = st.in_hdr[`IHC_EN_GKIND];
				f_d.protection_active    = st.in_hdr[`IHC_EN_PROT];
				f_d.payload_unit_offset  = st.in_hdr[`IHC_EN_PUOFF];
				f_d.payload_unit_kind    = st.in_hdr[`IHC_EN_PUKIND];
				f_d.classification_match = st.in_hdr[`IHC_EN_CLASS];
				f_d.label_hop_limit      = st.in_hdr[`IHC_EN_TTL];
				f_d.label_bottom_flag    = st.in_hdr[`IHC_EN_SBIT];
				f_d.next_header_kind     = st.in_hdr[`IHC_EN_NEXT];
				f_d.halfword_strip_count = st.in_hdr[`IHC_EN_STRIP];
				e_d[`IHC_ERR_RSV] = (|st.in_hdr[`IHC_EN_RSVA]) |
					(|st.in_hdr[`IHC_EN_RSVB]);
				e_d[`IHC_ERR_GKIND] = !st.in_hdr[`IHC_EN_GKIND];
				e_d[`IHC_ERR_CODE] = (st.in_hdr[`IHC_EN_PUKIND] == IHC_PU_RSV) |
					(st.in_hdr[`IHC_EN_NEXT] == IHC_NEXT_RSV);
			end
			IHC_LAYOUT_UCAST: begin
				f_d.egress_router_leg = st.in_hdr[`IHC_UC_LEG];
				f_d.next_hop_mac      = st.in_hdr[`IHC_UC_MAC];
				e_d[`IHC_ERR_RSV]     = |st.in_hdr[`IHC_UC_RSV];
			end
			IHC_LAYOUT_MCAST: begin
				f_d.multicast_group_index = st.in_hdr[`IHC_MC_GRP];
				f_d.egress_router_leg     = st.in_hdr[`IHC_MC_LEG];
				f_d.routed_copy_count     = st.in_hdr[`IHC_MC_COPY];
				e_d[`IHC_ERR_RSV]         = |st.in_hdr[`IHC_MC_RSV];
			end
			IHC_LAYOUT_INJECT: begin
				f_d.port_mask     = st.in_hdr[`IHC_INJ_MASK];
				e_d[`IHC_ERR_RSV] = |st.in_hdr[`IHC_INJ_RSV];
			end
			default: e_d[`IHC_ERR_MODE] = 1'b1;
		endcase
	end

	// Registered result, one cycle after the request
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			st.out_valid  <= 1'b0;
			st.out_fields <= '0;
			st.out_err    <= '0;
		end else begin
			st.out_valid <= st.in_valid;
			if (st.in_valid) begin
				st.out_fields <= f_d;
				st.out_err    <= e_d;
			end
		end
	end

	assign st.out_hdr = '0;
endmodule : ihc_parse
`default_nettype wire

/* design/ihc_top.sv */
// Purpose: Internal frame header codec, build and parse sides
// Assumes: Single core clock, synchronous strobes, fields one cycle
// Notes:   Header is handled as one 224-bit parallel word
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "ihc_defs.svh"
module ihc_top (
	input  wire logic                core_clk,
	input  wire logic                arst_n,
	input  wire logic [7:0]          reg_addr,
	input  wire logic [31:0]         reg_wdata,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	output var  logic [31:0]         reg_rdata,
	input  wire logic                xtr_req,
	input  wire ihc_pkg::ihc_fields_s xtr_fields,
	output var  logic                xtr_hdr_valid,
	output var  ihc_pkg::ihc_hdr_t   xtr_hdr,
	input  wire logic                inj_req,
	input  wire ihc_pkg::ihc_hdr_t   inj_hdr,
	output var  logic                inj_valid,
	output var  logic                inj_drop,
	output var  ihc_pkg::ihc_fields_s inj_fields,
	output var  ihc_pkg::ihc_err_t   inj_err,
	output var  logic [8:0]          inj_strip_bytes,
	output var  logic                rw_hop_update,
	output var  logic                rw_mac_exchange,
	output var  logic [1:0]          rw_tag_select,
	output var  logic [5:0]          rw_pop_bytes,
	output var  logic [7:0]          rw_pdu_bytes,
	output var  logic [1:0]          rw_next_kind,
	output var  logic                rw_ucast_route,
	output var  logic                rw_mcast_route
);
	import ihc_pkg::*;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Halfword count to byte count
	function automatic logic [7:0] ihc_hw2b(input logic [6:0] hw);
		return {hw, 1'b0};
	endfunction : ihc_hw2b

	// Exact register address match on all eight bits
	function automatic logic ihc_hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction : ihc_hit

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [31:0] ctrl_q;
	ihc_ts_t     time_q;
	logic [31:0] bcnt_q;
	logic [31:0] pcnt_q;
	logic [31:0] ecnt_q;
	ihc_err_t    cause_q;
	logic [31:0] rdata_d;
	logic        bad_w;
	logic        encapsulation_layout_w;
	ihc_fields_s pf_w;
	logic [6:0]  pdu_hw_w;

	ihc_stage_if bld_if ();
	ihc_stage_if prs_if ();

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	// Control: enables, drop policy, prefix length
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_q <= `IHC_CTRL_RST;
		end else if (reg_wr && ihc_hit(reg_addr, `IHC_REG_CTRL)) begin
			ctrl_q <= reg_wdata;
		end
	end

	// Free-running nanosecond time, loadable by software
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			time_q <= `IHC_CNT_RST;
		end else if (reg_wr && ihc_hit(reg_addr, `IHC_REG_TIME)) begin
			time_q <= reg_wdata;
		end else begin
			time_q <= time_q + 32'(`IHC_NS_PER_CYC);
		end
	end

	// Sticky error causes, write one to clear, new cause wins
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cause_q <= '0;
		end else begin
			cause_q <= (cause_q & ~((reg_wr && ihc_hit(reg_addr, `IHC_REG_CAUSE)) ?
				reg_wdata[`IHC_ERR_W-1:0] : ihc_err_t'(0))) |
				(prs_if.out_valid ? prs_if.out_err : ihc_err_t'(0));
		end
	end

	// ----------------------------------------
	// Register reads
	// ----------------------------------------
	// Read mux, unmapped addresses read zero
	always_comb begin
		rdata_d = '0;
		case (reg_addr)
			`IHC_REG_CTRL:  rdata_d = ctrl_q;
			`IHC_REG_TIME:  rdata_d = time_q;
			`IHC_REG_BCNT:  rdata_d = bcnt_q;
			`IHC_REG_PCNT:  rdata_d = pcnt_q;
			`IHC_REG_ECNT:  rdata_d = ecnt_q;
			`IHC_REG_CAUSE: rdata_d = 32'(cause_q);
			default:        rdata_d = '0;
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= '0;
		end else begin
			reg_rdata <= reg_rd ? rdata_d : 32'h0000_0000;
		end
	end

	// ----------------------------------------
	// Extraction side: header build
	// ----------------------------------------
	// Request gated by build enable
	assign bld_if.in_valid  = xtr_req && ctrl_q[`IHC_CTRL_BLD];
	assign bld_if.in_fields = xtr_fields;
	assign bld_if.in_hdr    = '0;

	ihc_build u_build (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.time_ns  (time_q),
		.st       (bld_if.stage)
	);

	// Header out, registered once more after the builder stage
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			xtr_hdr_valid <= 1'b0;
			xtr_hdr       <= '0;
		end else begin
			xtr_hdr_valid <= bld_if.out_valid;
			if (bld_if.out_valid) begin
				xtr_hdr <= bld_if.out_hdr;
			end
		end
	end

	// Built header count
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			bcnt_q <= `IHC_CNT_RST;
		end else if (reg_wr && ihc_hit(reg_addr, `IHC_REG_BCNT)) begin
			bcnt_q <= reg_wdata;
		end else if (bld_if.out_valid) begin
			bcnt_q <= bcnt_q + 32'h0000_0001;
		end
	end

	// ----------------------------------------
	// Injection side: header parse
	// ----------------------------------------
	// Request gated by parse enable
	assign prs_if.in_valid  = inj_req && ctrl_q[`IHC_CTRL_PRS];
	assign prs_if.in_hdr    = inj_hdr;
	assign prs_if.in_fields = '0;

	ihc_parse u_parse (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.st       (prs_if.stage)
	);

	// Parse result classification
	assign pf_w     = prs_if.out_fields;
	assign bad_w    = |prs_if.out_err;
	assign encapsulation_layout_w  = pf_w.destination_layout_select == IHC_LAYOUT_ENCAPSULATION_LAYOUT;
	assign pdu_hw_w = 7'(pf_w.halfword_strip_count) + 7'(pf_w.payload_unit_offset);

	// Accept or drop, fields and error code out
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			inj_valid  <= 1'b0;
			inj_drop   <= 1'b0;
			inj_fields <= '0;
			inj_err    <= '0;
		end else begin
			inj_valid <= prs_if.out_valid && !(bad_w && ctrl_q[`IHC_CTRL_DROP]);
			inj_drop  <= prs_if.out_valid && bad_w && ctrl_q[`IHC_CTRL_DROP];
			if (prs_if.out_valid) begin
				inj_fields <= pf_w;
				inj_err    <= prs_if.out_err;
			end
		end
	end

	// Bytes to drop ahead of the frame before front port transmit
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			inj_strip_bytes <= '0;
		end else if (prs_if.out_valid) begin
			inj_strip_bytes <= 9'(`IHC_HDR_BYTES) + 9'(ctrl_q[`IHC_CTRL_PFX]);
		end
	end

	// ----------------------------------------
	// Rewriter actions
	// ----------------------------------------
	// Encapsulation actions, zero for other layouts
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rw_hop_update   <= 1'b0;
			rw_mac_exchange <= 1'b0;
			rw_tag_select   <= '0;
			rw_pop_bytes    <= '0;
			rw_pdu_bytes    <= '0;
			rw_next_kind    <= '0;
		end else if (prs_if.out_valid) begin
			rw_hop_update   <= encapsulation_layout_w && pf_w.routed_hop_update;
			rw_mac_exchange <= encapsulation_layout_w && pf_w.mac_exchange;
			rw_tag_select   <= encapsulation_layout_w ? pf_w.tag_protocol_select : 2'h0;
			rw_pop_bytes    <= encapsulation_layout_w ?
				6'(ihc_hw2b(7'(pf_w.halfword_strip_count))) : 6'h00;
			rw_pdu_bytes    <= encapsulation_layout_w ? ihc_hw2b(pdu_hw_w) : 8'h00;
			rw_next_kind    <= encapsulation_layout_w ? pf_w.next_header_kind : 2'h0;
		end
	end

	// Routing layout indications
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rw_ucast_route <= 1'b0;
			rw_mcast_route <= 1'b0;
		end else if (prs_if.out_valid) begin
			rw_ucast_route <= pf_w.destination_layout_select == IHC_LAYOUT_UCAST;
			rw_mcast_route <= pf_w.destination_layout_select == IHC_LAYOUT_MCAST;
		end
	end

	// ----------------------------------------
	// Statistics
	// ----------------------------------------
	// Parsed header count
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pcnt_q <= `IHC_CNT_RST;
		end else if (reg_wr && ihc_hit(reg_addr, `IHC_REG_PCNT)) begin
			pcnt_q <= reg_wdata;
		end else if (prs_if.out_valid) begin
			pcnt_q <= pcnt_q + 32'h0000_0001;
		end
	end

	// Faulty header count
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ecnt_q <= `IHC_CNT_RST;
		end else if (reg_wr && ihc_hit(reg_addr, `IHC_REG_ECNT)) begin
			ecnt_q <= reg_wdata;
		end else if (prs_if.out_valid && bad_w) begin
			ecnt_q <= ecnt_q + 32'h0000_0001;
		end
	end
endmodule : ihc_top
`default_nettype wire

/* dv/ihc_top_sva.sv */
// Purpose: Port-level checks of the header codec
// Assumes: Single core clock, control word tracked from bus writes
// Notes:   Bound to ihc_top
`timescale 1ns/10ps
`default_nettype none
module ihc_top_chk (
	input wire logic                 core_clk,
	input wire logic                 arst_n,
	input wire logic [7:0]           reg_addr,
	input wire logic [31:0]          reg_wdata,
	input wire logic                 reg_wr,
	input wire logic                 xtr_req,
	input wire ihc_pkg::ihc_fields_s xtr_fields,
	input wire logic                 xtr_hdr_valid,
	input wire ihc_pkg::ihc_hdr_t    xtr_hdr,
	input wire logic                 inj_req,
	input wire ihc_pkg::ihc_hdr_t    inj_hdr,
	input wire logic                 inj_valid,
	input wire logic                 inj_drop,
	input wire logic [8:0]           inj_strip_bytes,
	input wire logic                 rw_hop_update,
	input wire logic                 rw_mac_exchange,
	input wire logic [5:0]           rw_pop_bytes,
	input wire logic [7:0]           rw_pdu_bytes,
	input wire logic                 rw_ucast_route,
	input wire logic                 rw_mcast_route
);
	import ihc_pkg::*;
	logic [15:0] ctrl_q;
	logic        bld, prs, enc;
	// Shadow of the control word
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) ctrl_q <= 16'h0003;
		else if (reg_wr && reg_addr == 8'h00) ctrl_q <= reg_wdata[15:0];
	end
	// Accepted requests
	assign bld = xtr_req & ctrl_q[0];
	assign prs = inj_req & ctrl_q[1];
	assign enc = prs & (inj_hdr[40:38] == 3'h0);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	a_build_answer: assert property (bld |-> ##2 xtr_hdr_valid)
		else $error("build answer missing");
	a_no_stray_header: assert property (!bld |-> ##2 !xtr_hdr_valid)
		else $error("header without request");
	a_time_step: assert property (bld ##1 bld |-> ##2
		xtr_hdr[223:192] == $past(xtr_hdr[223:192]) + 32'h14) else $error("time step wrong");
	a_stack_kept: assert property (bld |-> ##2
		xtr_hdr[127:38] == {$past(xtr_fields.stack_section, 2), xtr_hdr[47:41],
		$past(xtr_fields.destination_layout_select, 2)}) else $error("stack or mode wrong");
	a_encapsulation_layout_zero: assert property (xtr_hdr_valid && xtr_hdr[40:38] == 3'h0 |->
		xtr_hdr[191:190] == 2'h0 && xtr_hdr[185:184] == 2'h0 && xtr_hdr[137:135] == 3'h0)
		else $error("encapsulation_layout reserved bits set");
	a_route_zero: assert property (xtr_hdr_valid |->
		(xtr_hdr[40:38] != 3'h1 || xtr_hdr[191:183] == 9'h000) &&
		(xtr_hdr[40:38] != 3'h2 || xtr_hdr[191:152] == 40'h0) &&
		(xtr_hdr[40:38] != 3'h3 || xtr_hdr[191:181] == 11'h000)) else $error("reserved set");
	a_parse_answer: assert property (prs |-> ##2 (inj_valid ^ inj_drop))
		else $error("parse answer missing");
	a_rw_flags: assert property (enc |-> ##2 rw_hop_update == $past(inj_hdr[189], 2) &&
		rw_mac_exchange == $past(inj_hdr[188], 2)) else $error("rewriter flags wrong");
	a_strip_offset: assert property (enc |-> ##2
		rw_pop_bytes == 2 * $past(inj_hdr[132:128], 2) &&
		rw_pdu_bytes == 2 * ($past(inj_hdr[132:128], 2) + $past(inj_hdr[171:166], 2)))
		else $error("strip counts wrong");
	a_route_kind: assert property (prs |-> ##2
		rw_ucast_route == ($past(inj_hdr[40:38], 2) == 3'h1) &&
		rw_mcast_route == ($past(inj_hdr[40:38], 2) == 3'h2)) else $error("route kind wrong");
	a_strip_bytes: assert property (prs |-> ##2
		inj_strip_bytes == 9'h01C + $past(ctrl_q[15:8], 2)) else $error("strip bytes wrong");
	c_build_pair: cover property (bld ##1 bld);
	c_parse_ok: cover property (enc ##2 inj_valid);
	c_parse_drop: cover property (prs ##2 inj_drop);
endmodule : ihc_top_chk
bind ihc_top ihc_top_chk u_ihc_top_chk (.*);
`default_nettype wire

/* dv/ihc_cpu_side.sv */
// Purpose: Far-side injector feeding headers to the codec
// Assumes: Bench asks for one header at a time
// Notes:   Idle header lines toggle so stale data never looks valid
`timescale 1ns/10ps
`default_nettype none
module ihc_cpu_side (
	input  wire logic              core_clk,
	input  wire logic              arst_n,
	input  wire logic              send,
	input  wire ihc_pkg::ihc_hdr_t hdr_in,
	output var  logic              inj_req,
	output var  ihc_pkg::ihc_hdr_t inj_hdr
);
	import ihc_pkg::*;
	// One header word per request
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			inj_req <= 1'b0;
			inj_hdr <= '0;
		end else begin
			inj_req <= send;
			if (!send) inj_hdr <= ~inj_hdr;
			else if (hdr_in[40:38] == 3'h3) inj_hdr <= {hdr_in[223:192], 11'h000, hdr_in[180:0]};
			else inj_hdr <= hdr_in;
		end
	end
endmodule : ihc_cpu_side
`default_nettype wire

/* dv/internal_frame_header_codec_test.sv */
// Purpose: Self-checking bench of the header codec
// Assumes: Expected results queued by the drivers
// Notes:   Seeded random fields and headers
`timescale 1ns/10ps
`default_nettype none
`include "ihc_defs.svh"
module internal_frame_header_codec_test;
	import ihc_pkg::*;
	logic        core_clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, xtr_req = 0, send = 0;
	logic        rd_d = 0, den = 0, xtr_hdr_valid, inj_req, inj_valid, inj_drop;
	logic        rw_hop_update, rw_mac_exchange, rw_ucast_route, rw_mcast_route;
	logic [1:0]  rw_tag_select, rw_next_kind;
	logic [5:0]  rw_pop_bytes;
	logic [7:0]  reg_addr = 0, pfx = 0, rw_pdu_bytes;
	logic [8:0]  inj_strip_bytes;
	logic [31:0] reg_wdata = 0, reg_rdata, rq[$];
	logic [73:0] pq[$], pe;
	ihc_err_t    inj_err;
	ihc_fields_s xtr_fields = '0, f;
	ihc_hdr_t    hdr_in = '0, xtr_hdr, inj_hdr, h, bq[$];
	int          miscompares = 0, checks_done = 0;
	ihc_top u_ihc_top (.inj_fields(), .*);
	ihc_cpu_side u_ihc_cpu_side (.*);
	// Clock and watchdog
	always #10 core_clk = ~core_clk;
	initial begin
		#100000;
		miscompares++;
		results();
	end
	// Random fields of one layout, kept free of faults
	function automatic ihc_fields_s rf(logic [2:0] md);
		logic [$bits(ihc_fields_s)-1:0] v;
		ihc_fields_s r;
		for (int i = 0; i < 12; i++) v = {v, $urandom};
		r = v;
		r.destination_layout_select = md;
		r.generic_index_kind = 1'b1;
		if (r.payload_unit_kind == 3'h6) r.payload_unit_kind = 3'h7;
		if (r.next_header_kind == 2'h3) r.next_header_kind = 2'h2;
		return r;
	endfunction : rf
	// Expected header for given fields
	function automatic ihc_hdr_t bh(ihc_fields_s r, ihc_ts_t t);
		logic [63:0] d;
		logic [47:0] lo;
		case (r.destination_layout_select)
			3'h0: d = {2'h0, r.routed_hop_update, r.mac_exchange, r.tag_protocol_select, 2'h0,
				r.generic_index, r.generic_index_kind, r.protection_active, r.payload_unit_offset,
				r.payload_unit_kind, r.classification_match, r.label_hop_limit,
				r.label_bottom_flag, 3'h0, r.next_header_kind, r.halfword_strip_count};
			3'h1: d = {9'h000, r.egress_router_leg, r.next_hop_mac};
			3'h2: d = {40'h0, r.multicast_group_index, r.egress_router_leg, r.routed_copy_count};
			3'h3: d = {11'h000, r.port_mask};
			default: d = '0;
		endcase
		lo = r.low_fields;
		lo[40:38] = r.destination_layout_select;
		return {t, d, r.stack_section, lo};
	endfunction : bh
	// Masked comparison
	task automatic cmp(string n, logic [223:0] e, logic [223:0] g, logic [223:0] m);
		checks_done++;
		if ((e & m) !== (g & m)) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, e & m, g & m);
		end
	endtask : cmp
	// Register bus cycle, read result queued
	task automatic acc(bit w, logic [7:0] a, logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		if (w) reg_wr <= 1'b1;
		else reg_rd <= 1'b1;
		if (!w) rq.push_back(d);
		@(posedge core_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
	endtask : acc
	// Header injection with expected parse result
	task automatic par(ihc_hdr_t hh, ihc_err_t e);
		logic [36:0] x, m;
		logic [7:0]  pd;
		pd = 2 * (hh[132:128] + hh[171:166]);
		x = {(e == 4'h0) | ~den, (e != 4'h0) & den, e, hh[189:186], hh[132:128], 1'b0, pd,
			hh[134:133], hh[40:38] == 3'h1, hh[40:38] == 3'h2, 9'h01C + pfx};
		m = (hh[40:38] == 3'h0) ? '1 : {6'h3F, 20'h0, 11'h7FF};
		@(posedge core_clk);
		send <= 1'b1;
		hdr_in <= hh;
		pq.push_back({m, x});
		@(posedge core_clk);
		send <= 1'b0;
	endtask : par
	// Time load then two back-to-back builds
	task automatic bld(logic [2:0] md);
		ihc_ts_t     t;
		ihc_fields_s r;
		t = $urandom;
		acc(1, `IHC_REG_TIME, t);
		for (int i = 0; i < 2; i++) begin
			r = rf(md);
			xtr_req <= 1'b1;
			xtr_fields <= r;
			bq.push_back(bh(r, t + `IHC_NS_PER_CYC * i));
			@(posedge core_clk);
		end
		xtr_req <= 1'b0;
	endtask : bld
	// Output monitor
	always @(posedge core_clk) begin
		if (rd_d) cmp("reg_rdata", rq.pop_front(), reg_rdata, '1);
		if (xtr_hdr_valid === 1'b1) cmp("xtr_hdr", bq.pop_front(), xtr_hdr, '1);
		if (inj_valid === 1'b1 || inj_drop === 1'b1) begin
			pe = pq.pop_front();
			cmp("parse", pe[36:0], {inj_valid, inj_drop, inj_err, rw_hop_update, rw_mac_exchange,
				rw_tag_select, rw_pop_bytes, rw_pdu_bytes, rw_next_kind, rw_ucast_route,
				rw_mcast_route, inj_strip_bytes}, pe[73:37]);
		end
		rd_d <= reg_rd;
	end
	// Test sequence
	initial begin
		void'($urandom(44));
		repeat (4) @(posedge core_clk);
		arst_n <= 1'b1;
		acc(0, `IHC_REG_CTRL, `IHC_CTRL_RST);
		acc(0, 8'h20, 32'h0000_0000);
		h = bh(rf(3'h0), 32'h0);
		h[173] = 1'b0;
		par(h, 4'h4);
		acc(1, `IHC_REG_CTRL, 32'h0000_0B07);
		den = 1'b1;
		pfx = 8'h0B;
		for (int k = 0; k < 8; k++) if (k != 6) begin
			f = rf(3'h0);
			f.payload_unit_kind = 3'(k);
			f.tag_protocol_select = 2'(k);
			f.next_header_kind = 2'(k % 3);
			if (k == 7) {f.halfword_strip_count, f.payload_unit_offset} = '1;
			par(bh(f, $urandom), 4'h0);
		end
		for (int k = 1; k < 4; k++) par(bh(rf(3'(k)), $urandom), 4'h0);
		par(bh(rf(3'h5), 32'h0), 4'h1);
		h = bh(rf(3'h0), 32'h0);
		h[190] = 1'b1;
		par(h, 4'h2);
		h[190] = 1'b0;
		h[165:163] = 3'h6;
		par(h, 4'h8);
		for (int m = 0; m < 5; m++) bld(3'(m));
		acc(0, `IHC_REG_BCNT, 32'h0000_000A);
		acc(1, `IHC_REG_CTRL, 32'h0000_0B06);
		xtr_req <= 1'b1;
		@(posedge core_clk);
		xtr_req <= 1'b0;
		repeat (6) @(posedge core_clk);
		results();
	end
	// Verdict
	task automatic results;
		if (bq.size() + pq.size() + rq.size() != 0) miscompares++;
		$display("checks_done %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : results
endmodule : internal_frame_header_codec_test
`default_nettype wire
